// ==== rtl/tawg_guard.sv ====
// Timed access write guard: key sequencer, window and guarded bits
`timescale 1ns/10ps
module tawg_guard (
	input wire logic sys_clk,
	input wire logic rst,
	input tawg_pkg::tawg_sfr_wr_s sfr_wr,
	input tawg_pkg::tawg_prot_wr_s prot_wr,
	input wire logic por_event,
	output logic [7:0] guarded_bits,
	output logic window_open,
	output logic key_armed,
	output logic watchdog_reset_enable
);
	// ------------------------------------------------------------
	// Key decode
	// ------------------------------------------------------------
	logic key_wr;
	logic key_first;
	logic key_second;
	logic key_other;
	logic unlock;
	logic [tawg_pkg::CNT_W-1:0] key_cnt;
	logic [tawg_pkg::CNT_W-1:0] win_cnt;

	function automatic logic is_key(input tawg_pkg::tawg_sfr_wr_s w,
		input logic [7:0] v);
		is_key = w.valid && (w.addr == tawg_pkg::UNLOCK_KEY_ADDR)
			&& (w.data == v);
	endfunction

	assign key_wr = sfr_wr.valid
		&& (sfr_wr.addr == tawg_pkg::UNLOCK_KEY_ADDR);
	assign key_first = is_key(sfr_wr, tawg_pkg::KEY_FIRST);
	assign key_second = is_key(sfr_wr, tawg_pkg::KEY_SECOND);
	assign key_other = key_wr && !key_first && !key_second;
	// Late 55h finds the wait counter at zero
	assign unlock = key_second && key_armed;

	// ------------------------------------------------------------
	// Wait counter and window counter
	// ------------------------------------------------------------
	tawg_down_counter #(
		.W(tawg_pkg::CNT_W)
	) u_key_wait (
		.sys_clk(sys_clk),
		.rst(rst),
		.load(key_first),
		.load_val(tawg_pkg::KEY_WAIT_CNT),
		.clear(key_second || key_other),
		.active(key_armed),
		.count(key_cnt)
	);

	tawg_down_counter #(
		.W(tawg_pkg::CNT_W)
	) u_window (
		.sys_clk(sys_clk),
		.rst(rst),
		.load(unlock),
		.load_val(tawg_pkg::WINDOW_CNT),
		.clear(1'b0),
		.active(window_open),
		.count(win_cnt)
	);

	// ------------------------------------------------------------
	// Guarded bits
	// ------------------------------------------------------------
	logic [7:0] guard_q;
	logic [7:0] guard_d;

	always_comb
	begin
		guard_d = guard_q;
		// Writes are taken in the window, even the first cycle
		if (prot_wr.valid && window_open)
			guard_d = (guard_q & ~prot_wr.mask)
				| (prot_wr.data & prot_wr.mask);
		// Hardware set wins over a software clear
		if (por_event)
			guard_d = guard_d | tawg_pkg::POR_MASK;
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			guard_q <= tawg_pkg::GUARD_RESET;
		else
			guard_q <= guard_d;
	end

	assign guarded_bits = guard_q;
	assign watchdog_reset_enable = guard_q[tawg_pkg::GB_WDT_RESET_EN];

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	sequence s_aa;
		key_first;
	endsequence

	sequence s_aa_quiet;
		s_aa ##1 (!key_wr)[*2];
	endsequence

	sequence s_late_55;
		s_aa ##1 (!key_wr)[*3] ##1 key_second;
	endsequence

	property p_aa_arms;
		s_aa_quiet |-> key_armed ##1 key_armed;
	endproperty
	a_aa_arms: assert property (p_aa_arms)
		else $error("AA write did not arm three cycles");

	property p_key_expires;
		s_aa_quiet ##1 !key_first |=> !key_armed;
	endproperty
	a_key_expires: assert property (p_key_expires)
		else $error("Key wait outlasted three cycles");

	property p_unlock_opens;
		s_aa ##[1:3] (key_second && key_armed) |=> window_open;
	endproperty
	a_unlock_opens: assert property (p_unlock_opens)
		else $error("Timely 55h did not open window");

	property p_no_open_alone;
		!(key_second && key_armed) && !window_open
			|=> !window_open;
	endproperty
	a_no_open_alone: assert property (p_no_open_alone)
		else $error("Window opened without armed 55h");

	property p_unlock_clears;
		unlock |=> !key_armed;
	endproperty
	a_unlock_clears: assert property (p_unlock_clears)
		else $error("Key still armed after unlock");

	property p_window_len;
		unlock |=> window_open[*3] ##1 (!window_open || $past(unlock)
			|| $past(unlock, 2) || $past(unlock, 3));
	endproperty
	a_window_len: assert property (p_window_len)
		else $error("Window length not three cycles");

	property p_drop_outside;
		prot_wr.valid && !window_open
			|=> (guard_q & ~tawg_pkg::POR_MASK)
			== ($past(guard_q) & ~tawg_pkg::POR_MASK);
	endproperty
	a_drop_outside: assert property (p_drop_outside)
		else $error("Guarded bits changed outside window");

	property p_write_masked;
		prot_wr.valid && window_open
			|=> ((guard_q ^ $past(guard_q)) & ~$past(prot_wr.mask)
			& ~tawg_pkg::POR_MASK) == 8'h00;
	endproperty
	a_write_masked: assert property (p_write_masked)
		else $error("Unmasked guarded bit changed");

	property p_hold_idle;
		!prot_wr.valid && !por_event |=> $stable(guard_q);
	endproperty
	a_hold_idle: assert property (p_hold_idle)
		else $error("Guarded bits changed with no write");

	property p_addr_decode;
		sfr_wr.valid && (sfr_wr.addr != tawg_pkg::UNLOCK_KEY_ADDR)
			&& key_cnt == '0 |=> !key_armed;
	endproperty
	a_addr_decode: assert property (p_addr_decode)
		else $error("Write to other address armed key");

	property p_late_55;
		s_late_55 |=> !$rose(window_open);
	endproperty
	a_late_55: assert property (p_late_55)
		else $error("Late 55h opened window");

	property p_write_inside;
		prot_wr.valid && window_open
			|=> ((guard_q ^ $past(prot_wr.data)) & $past(prot_wr.mask)
			& ~tawg_pkg::POR_MASK) == 8'h00;
	endproperty
	a_write_inside: assert property (p_write_inside)
		else $error("Guarded write in window not applied");

	property p_next_instr;
		unlock ##3 prot_wr.valid |-> window_open;
	endproperty
	a_next_instr: assert property (p_next_instr)
		else $error("Window shut before third cycle write");

	property p_cancel;
		key_other |=> !key_armed;
	endproperty
	a_cancel: assert property (p_cancel)
		else $error("Wrong key value did not cancel");

	property p_por_set;
		por_event |=> guard_q[tawg_pkg::GB_POR_FLAG];
	endproperty
	a_por_set: assert property (p_por_set)
		else $error("Reset flag not set by hardware");

	property p_win_cnt;
		$rose(window_open) |-> win_cnt == tawg_pkg::WINDOW_CNT;
	endproperty
	a_win_cnt: assert property (p_win_cnt)
		else $error("Window not opened for three cycles");
endmodule

// ==== rtl/tawg_pkg.sv ====
// Shared constants and carriers for the timed access write guard
package tawg_pkg;

	// ------------------------------------------------------------
	// Key register and key values
	// ------------------------------------------------------------
	localparam logic [7:0] UNLOCK_KEY_ADDR = 8'hC7;
	localparam logic [7:0] KEY_FIRST = 8'hAA;
	localparam logic [7:0] KEY_SECOND = 8'h55;

	// ------------------------------------------------------------
	// Timing in machine cycles (one sys_clk per machine cycle)
	// ------------------------------------------------------------
	localparam int KEY_WAIT_MC = 3;
	localparam int WINDOW_MC = 3;
	localparam int CNT_W = 2;
	localparam logic [CNT_W-1:0] KEY_WAIT_CNT = CNT_W'(KEY_WAIT_MC);
	localparam logic [CNT_W-1:0] WINDOW_CNT = CNT_W'(WINDOW_MC);

	// ------------------------------------------------------------
	// Guarded bit positions and reset value
	// ------------------------------------------------------------
	localparam int GB_WDT_RESET_EN = 0;
	localparam int GB_WDT_RUN = 1;
	localparam int GB_WDT_CLEAR = 2;
	localparam int GB_WDT_PERIOD_LO = 3;
	localparam int GB_WDT_PERIOD_HI = 4;
	localparam int GB_ROM_SIZE_ADJ = 5;
	localparam int GB_WAIT_STATE = 6;
	localparam int GB_POR_FLAG = 7;
	localparam logic [7:0] GUARD_RESET = 8'h80;
	localparam logic [7:0] POR_MASK = 8'h80;

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic valid;
		logic [7:0] addr;
		logic [7:0] data;
	} tawg_sfr_wr_s;

	typedef struct packed {
		logic valid;
		logic [7:0] mask;
		logic [7:0] data;
	} tawg_prot_wr_s;

endpackage

// ==== rtl/tawg_down_counter.sv ====
// Loadable down counter whose non-zero state marks an open interval
`timescale 1ns/10ps
module tawg_down_counter #(
	parameter int W = 2
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic load,
	input wire logic [W-1:0] load_val,
	input wire logic clear,
	output logic active,
	output logic [W-1:0] count
);
	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;

	always_comb
	begin
		cnt_d = cnt_q;
		if (load)
			cnt_d = load_val;
		else if (clear)
			cnt_d = '0;
		else if (cnt_q != '0)
			cnt_d = cnt_q - W'(1);
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			cnt_q <= '0;
		else
			cnt_q <= cnt_d;
	end

	assign active = (cnt_q != '0);
	assign count = cnt_q;
endmodule

// ==== dv/timed_access_write_guard_test.sv ====
// Self-checking bench for the timed access write guard
`timescale 1ns/10ps
module timed_access_write_guard_test;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	tawg_pkg::tawg_sfr_wr_s sfr_wr = '0;
	tawg_pkg::tawg_prot_wr_s prot_wr = '0;
	logic por_event = 1'b0;
	logic chk = 1'b0;
	logic [7:0] guarded_bits;
	logic window_open;
	logic key_armed;
	logic watchdog_reset_enable;
	logic [7:0] model_q = 8'h80;
	logic [7:0] mids [3] = '{8'h33, 8'hFF, 8'h01};
	logic [10:0] exp_q [$];
	int bad_count = 0;
	int samples_checked = 0;
	int cycles = 0;

	tawg_guard dut (.sys_clk(sys_clk), .rst(rst), .sfr_wr(sfr_wr),
		.prot_wr(prot_wr), .por_event(por_event),
		.guarded_bits(guarded_bits), .window_open(window_open),
		.key_armed(key_armed),
		.watchdog_reset_enable(watchdog_reset_enable));

	initial
	begin
		forever #25 sys_clk = ~sys_clk;
	end

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic check(input logic [10:0] seen, input logic [10:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic close_out();
		$display("Checked %0d, mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	function automatic logic [10:0] expv(input logic w, input logic a);
		return {model_q[0], w, a, model_q};
	endfunction

	// One machine cycle of stimulus
	task automatic cyc(input tawg_pkg::tawg_sfr_wr_s s,
		input tawg_pkg::tawg_prot_wr_s p, input logic pe, input logic c);
		@(posedge sys_clk);
		sfr_wr <= s;
		prot_wr <= p;
		por_event <= pe;
		chk <= c;
	endtask

	// Key pair with gap g, optional stray key, write w cycles later
	task automatic seq(input logic [7:0] addr, input int g,
		input logic [7:0] mid, input int w, input logic [7:0] mask,
		input logic [7:0] data);
		logic hit;
		logic op;
		hit = addr == tawg_pkg::UNLOCK_KEY_ADDR;
		op = hit && g <= 3 && mid == 8'h00;
		cyc('{1'b1, addr, tawg_pkg::KEY_FIRST}, '0, 1'b0, 1'b0);
		for (int i = 1; i < g; i++)
		begin
			if (i == 1)
				exp_q.push_back(expv(1'b0, hit));
			cyc('{mid != 8'h00 && i == 1, addr, mid}, '0, 1'b0, i == 1);
		end
		cyc('{1'b1, addr, tawg_pkg::KEY_SECOND}, '0, 1'b0, 1'b0);
		exp_q.push_back(expv(op, 1'b0));
		for (int j = 1; j <= w; j++)
			cyc('0, '{j == w, mask, data}, 1'b0, j == 1);
		if (op && w <= 3)
			model_q = (model_q & ~mask) | (data & mask);
		exp_q.push_back(expv(op && w <= 2, 1'b0));
		cyc('0, '0, 1'b0, 1'b1);
		repeat (4) cyc('0, '0, 1'b0, 1'b0);
	endtask

	// ------------------------------------------------------------
	// Result watcher and timeout
	// ------------------------------------------------------------
	always @(negedge sys_clk)
	begin
		if (chk)
			check({watchdog_reset_enable, window_open, key_armed,
				guarded_bits}, exp_q.pop_front());
	end

	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			bad_count++;
			close_out();
		end
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		void'($urandom(21));
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		exp_q.push_back(expv(1'b0, 1'b0));
		cyc('0, '0, 1'b0, 1'b1);
		for (int g = 1; g <= 4; g++)
			for (int w = 1; w <= 4; w++)
				seq(8'hC7, g, 8'h00, w, 8'($urandom), 8'($urandom));
		seq(8'hC6, 1, 8'h00, 1, 8'hFF, 8'h00);
		seq(8'hC8, 2, 8'h00, 1, 8'hFF, 8'h00);
		foreach (mids[k])
			seq(8'hC7, 3, mids[k], 1, 8'hFF, 8'($urandom));
		seq(8'hC7, 1, 8'h00, 1, 8'hFF, 8'h7F);
		seq(8'hC7, 3, 8'h00, 3, 8'hFF, 8'h00);
		model_q[7] = 1'b1;
		cyc('0, '0, 1'b1, 1'b0);
		exp_q.push_back(expv(1'b0, 1'b0));
		cyc('0, '0, 1'b0, 1'b1);
		cyc('0, '0, 1'b0, 1'b0);
		close_out();
	end
endmodule
